// ### bench/btn_prog_bench.sv
// Self-checking bench of the programming block with a flash model.
// Assumes short counts: hold 200, debounce 4, flash phase 8 cycles.
`timescale 1ns/1ps
module btn_prog_bench;
   logic                 clk = 0, resetn = 0, store_btn_n = 1, inc_btn_n = 1, joy_valid = 0;
   btn_prog_pkg::joy_s   joy = '0;      // Joystick position
   btn_prog_pkg::store_t stored_vals;   // Flash contents
   btn_prog_pkg::nvm_s   nvm_word;
   btn_prog_pkg::cal_s   cal_word;
   logic [6:0]           seg;
   logic                 nvm_wr, cal_wr, prog_mode, selftest_mode, run_mode;
   int                   bad_count = 0, check_count = 0, cyc = 0, wr_cnt = 0, w;
   int                   cal_cnt = 0, c;   // Calibration write pulses and a snapshot
   // 40 MHz clock
   always #12.5 clk = ~clk;
   btn_prog #(.HOLD_CYC(200), .DEB_CYC(4), .FLASH_CYC(8)) btn_prog_inst (.clk(clk),
      .resetn(resetn), .store_btn_n(store_btn_n), .inc_btn_n(inc_btn_n),
      .stored_vals(stored_vals), .joy_valid(joy_valid), .joy(joy), .nvm_wr(nvm_wr),
      .nvm_word(nvm_word), .cal_wr(cal_wr), .cal_word(cal_word), .seg(seg),
      .prog_mode(prog_mode), .selftest_mode(selftest_mode), .run_mode(run_mode));
   flash_model flash_model_inst (.clk(clk), .nvm_wr(nvm_wr), .nvm_word(nvm_word),
      .stored_vals(stored_vals));
   // Write counter and hang guard
   always @(posedge clk) begin
      cyc++;
      if (nvm_wr === 1'b1) wr_cnt++;
      if (cal_wr === 1'b1) cal_cnt++;
      if (cyc == 20000) begin
         bad_count++;
         end_of_test();
      end
   end
   task end_of_test;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : end_of_test
   task chk_word(input logic [47:0] got, input logic [47:0] exp);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk_word
   // Press long enough to pass debounce, then release as long
   task push(input logic s, input logic i);
      @(negedge clk);
      store_btn_n = ~s;
      inc_btn_n = ~i;
      repeat (12) @(negedge clk);
      store_btn_n = 1;
      inc_btn_n = 1;
      repeat (12) @(negedge clk);
   endtask : push
   // Reset with a button combination held, left held 100 cycles after release
   task start(input logic s, input logic i);
      @(negedge clk);
      resetn = 0;
      store_btn_n = ~s;
      inc_btn_n = ~i;
      repeat (16) @(negedge clk);
      resetn = 1;
      repeat (100) @(negedge clk);
   endtask : start
   task sample(input logic [15:0] v);
      @(negedge clk);
      joy = v;
      joy_valid = 1;
      @(negedge clk);
      joy_valid = 0;
   endtask : sample
   // Entry, edits, wrap and calibration
   task t_prog;
      start(1, 0);
      chk_word(48'(seg), 48'h49);
      chk_word(48'(prog_mode), 48'h0);
      repeat (150) @(negedge clk);
      store_btn_n = 1;
      chk_word(48'(prog_mode), 48'h1);
      for (int k = 0; k < 40 && seg !== 7'h06; k++) @(negedge clk);
      chk_word(48'(seg), 48'h06);
      w = wr_cnt;
      push(1, 0);
      chk_word(48'(wr_cnt - w), 48'h0);
      push(0, 1);
      push(1, 0);
      chk_word(48'(nvm_word), 48'h11);
      chk_word(48'(stored_vals[1]), 48'h1);
      push(0, 1);
      push(0, 1);
      push(1, 0);
      chk_word(48'(nvm_word), 48'h20);
      repeat (7) push(1, 0);
      chk_word(48'(wr_cnt - w), 48'h2);
      push(0, 1);
      for (int k = 0; k < 40 && seg !== 7'h5C; k++) @(negedge clk);
      chk_word(48'(seg), 48'h5C);
      sample(16'h1020);
      sample(16'hF005);
      sample(16'h8080);
      joy = 16'h7F81;
      c = cal_cnt;
      push(1, 0);
      chk_word(cal_word, 48'h1005_F080_7F81);
      chk_word(48'(cal_cnt - c), 48'h1);
      chk_word(48'(prog_mode), 1);
      push(0, 1);
   endtask : t_prog
   // Reset mid-edit, then self-test
   task t_selftest;
      start(0, 1);
      chk_word(48'(stored_vals[0]), 48'h0);
      repeat (150) @(negedge clk);
      inc_btn_n = 1;
      chk_word(48'(selftest_mode), 48'h1);
      chk_word(48'(prog_mode | run_mode), 48'h0);
   endtask : t_selftest
   // Plain start-up with no button held goes straight to normal running
   task t_run;
      start(0, 0);
      chk_word(48'(run_mode), 48'h1);
      chk_word(48'(prog_mode | selftest_mode), 48'h0);
      chk_word(48'(seg), 48'h0);
   endtask : t_run
   // Factory restore
   task t_defaults;
      w = wr_cnt;
      c = cal_cnt;
      start(1, 1);
      repeat (150) @(negedge clk);
      store_btn_n = 1;
      inc_btn_n = 1;
      for (int k = 0; k < 100 && run_mode !== 1'b1; k++) @(negedge clk);
      chk_word(48'(run_mode), 48'h1);
      chk_word(48'(wr_cnt - w), 48'hA);
      chk_word(48'(cal_cnt - c), 48'h1);
      chk_word(48'(stored_vals), 48'h70_0202_2500);
      chk_word(cal_word, 48'h0000_FFFF_8080);
   endtask : t_defaults
   initial begin
      t_prog();
      t_selftest();
      t_run();
      t_defaults();
      end_of_test();
   end
endmodule : btn_prog_bench

// ### bench/btn_prog_chk.sv
// Checker for the front-panel programming block.
// Assumes only the ports of btn_prog; bound below.
`timescale 1ns/1ps
module btn_prog_chk (
   input wire logic               clk,
   input wire logic               resetn,
   input wire logic               nvm_wr,
   input wire btn_prog_pkg::nvm_s nvm_word,
   input wire logic               cal_wr,
   input wire logic [6:0]         seg,
   input wire logic               prog_mode,
   input wire logic               selftest_mode,
   input wire logic               run_mode
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   // ---------------------------------------------------------------
   // Sequences
   // ---------------------------------------------------------------
   sequence defaults_done;
      cal_wr && !prog_mode;
   endsequence
   sequence mode_up;
      ##[1:4] run_mode;
   endsequence
   // ---------------------------------------------------------------
   // Properties
   // ---------------------------------------------------------------
   a_mode_hold: assert property (prog_mode |=> prog_mode)
      else $error("programming mode left");
   a_mode_excl: assert property (!(prog_mode && (selftest_mode || run_mode)))
      else $error("two modes at once");
   a_steady_wait: assert property (seg == btn_prog_pkg::SEG_STEADY |-> !prog_mode && !run_mode)
      else $error("steady pattern outside wait");
   a_store_idx: assert property (nvm_wr |-> nvm_word.idx <= 4'h9)
      else $error("write index out of list");
   a_motor_limit: assert property (nvm_wr && nvm_word.idx == 4'h1 |-> nvm_word.val <= 4'h1)
      else $error("motor mode code above one");
   a_press_once: assert property (nvm_wr && prog_mode |=> !nvm_wr [*4])
      else $error("writes too close");
   a_cal_pulse: assert property (cal_wr |=> !cal_wr)
      else $error("calibration write too long");
   a_defaults_run: assert property (defaults_done |-> mode_up)
      else $error("no start-up after defaults");
endmodule : btn_prog_chk
bind btn_prog btn_prog_chk btn_prog_chk_inst (.clk(clk), .resetn(resetn), .nvm_wr(nvm_wr),
   .nvm_word(nvm_word), .cal_wr(cal_wr), .seg(seg), .prog_mode(prog_mode),
   .selftest_mode(selftest_mode), .run_mode(run_mode));

// ### bench/flash_model.sv
// Flash model holding the ten stored parameter values.
// Assumes writes arrive as one-cycle nvm_wr pulses on clk.
`timescale 1ns/1ps
module flash_model (
   // Clock
   input  wire logic                 clk,
   // Write port
   input  wire logic                 nvm_wr,
   input  wire btn_prog_pkg::nvm_s   nvm_word,
   // Contents, kept over resets like real flash
   output btn_prog_pkg::store_t      stored_vals
);
   // Start from factory values; no reset input, so edits survive a reset
   initial stored_vals = 40'h70_0202_2500;
   // Index above nine is ignored rather than wrapped
   always @(posedge clk) begin
      if (nvm_wr === 1'b1 && nvm_word.idx < 4'hA) begin
         stored_vals[nvm_word.idx] <= nvm_word.val;
      end
   end
endmodule : flash_model

// ### hw/btn_prog.sv
// Front-panel programming block: two buttons, one seven-segment digit.
// Assumes buttons are raw active-low pins, the stored values and joystick
// samples come from logic on clk, and a flash writer takes one word a cycle.
`timescale 1ns/1ps
module btn_prog #(
   parameter int unsigned HOLD_CYC  = btn_prog_pkg::HOLD_CYCLES,
   parameter int unsigned DEB_CYC   = btn_prog_pkg::DEB_CYCLES,
   parameter int unsigned FLASH_CYC = btn_prog_pkg::FLASH_CYCLES
) (
   // Clock and reset
   input  wire logic                 clk,
   input  wire logic                 resetn,
   // Front-panel buttons, raw pins
   input  wire logic                 store_btn_n,
   input  wire logic                 inc_btn_n,
   // Values held in flash, read at any time
   input  wire btn_prog_pkg::store_t stored_vals,
   // Joystick samples
   input  wire logic                 joy_valid,
   input  wire btn_prog_pkg::joy_s   joy,
   // Flash write of one parameter
   output logic                      nvm_wr,
   output btn_prog_pkg::nvm_s        nvm_word,
   // Flash write of joystick calibration
   output logic                      cal_wr,
   output btn_prog_pkg::cal_s        cal_word,
   // Display
   output logic [6:0]                seg,
   // Selected mode
   output logic                      prog_mode,
   output logic                      selftest_mode,
   output logic                      run_mode
);

   // ---------------------------------------------------------------
   // Button synchroniser and debouncer
   // ---------------------------------------------------------------
   localparam int unsigned B_STORE = 1;        // Bit of the Program button
   localparam int unsigned B_INC   = 0;        // Bit of the Set button
   logic [1:0]  sync1_r;                       // First stage, read only by sync2_r
   logic [1:0]  sync2_r;                       // Synchronised, active high
   logic [1:0]  deb_r;                         // Debounced level
   logic [1:0]  deb_q_r;                       // Previous debounced level
   logic [31:0] deb_cnt_r [2];                 // Stability counters
   wire  [1:0]  press = deb_r & ~deb_q_r;      // One-cycle press edges
   wire         store_press = press[B_STORE];
   wire         inc_press   = press[B_INC];

   // Two flops before anything looks at the pins
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sync1_r <= 2'h0;
         sync2_r <= 2'h0;
      end else begin
         sync1_r <= {~store_btn_n, ~inc_btn_n};
         sync2_r <= sync1_r;
      end
   end

   // Level must stand a full debounce time before it is taken
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         deb_r        <= 2'h0;
         deb_q_r      <= 2'h0;
         deb_cnt_r[0] <= 32'h0000_0000;
         deb_cnt_r[1] <= 32'h0000_0000;
      end else begin
         deb_q_r <= deb_r;
         for (int i = 0; i < 2; i++) begin
            if (sync2_r[i] == deb_r[i]) begin
               deb_cnt_r[i] <= 32'h0000_0000;
            end else if (deb_cnt_r[i] == 32'(DEB_CYC - 1)) begin
               deb_r[i]     <= sync2_r[i];
               deb_cnt_r[i] <= 32'h0000_0000;
            end else begin
               deb_cnt_r[i] <= deb_cnt_r[i] + 32'h0000_0001;
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // Start-up hold timer
   // ---------------------------------------------------------------
   logic [1:0]  combo_r;                       // Button combination last cycle
   logic [31:0] hold_cnt_r;                    // Cycles the combination has stood
   wire hold_done  = (hold_cnt_r == 32'(HOLD_CYC - 1));
   // Debouncer needs time to report a button already down at reset
   wire settle_done = (hold_cnt_r == 32'(2 * DEB_CYC));

   // Restarts whenever the combination changes
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         combo_r    <= 2'h0;
         hold_cnt_r <= 32'h0000_0000;
      end else begin
         combo_r <= deb_r;
         if (combo_r != deb_r) begin
            hold_cnt_r <= 32'h0000_0000;
         end else if (!hold_done) begin
            hold_cnt_r <= hold_cnt_r + 32'h0000_0001;
         end
      end
   end

   // ---------------------------------------------------------------
   // Display phase: letter, blank, value, blank
   // ---------------------------------------------------------------
   logic [31:0] flash_cnt_r;
   logic [1:0]  phase_r;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         flash_cnt_r <= 32'h0000_0000;
         phase_r     <= 2'h0;
      end else if (flash_cnt_r == 32'(FLASH_CYC - 1)) begin
         flash_cnt_r <= 32'h0000_0000;
         phase_r     <= phase_r + 2'h1;
      end else begin
         flash_cnt_r <= flash_cnt_r + 32'h0000_0001;
      end
   end

   // ---------------------------------------------------------------
   // Main state machine
   // ---------------------------------------------------------------
   btn_prog_pkg::state_e state_r, state_nxt;
   logic [3:0]         idx_r, idx_nxt;        // Parameter being shown
   logic [3:0]         val_r, val_nxt;        // Value being edited
   logic               dirty_r, dirty_nxt;    // Value changed since shown
   logic               nvm_wr_r, nvm_wr_nxt;
   btn_prog_pkg::nvm_s nvm_r, nvm_nxt;
   logic               cal_wr_r, cal_wr_nxt;
   btn_prog_pkg::cal_s cal_out_r, cal_nxt;
   btn_prog_pkg::cal_s track_r;               // Running limits while calibrating

   // Next entry in the fixed list and its stored value
   wire       at_joy    = (idx_r == btn_prog_pkg::LAST_IDX);
   wire [3:0] next_idx  = at_joy ? btn_prog_pkg::FIRST_IDX : idx_r + 4'h1;
   wire [3:0] next_val  = (next_idx == btn_prog_pkg::LAST_IDX) ? btn_prog_pkg::VAL_ZERO
                                                               : stored_vals[next_idx];
   wire [3:0] first_val = stored_vals[btn_prog_pkg::FIRST_IDX];
   wire       at_max    = (val_r >= btn_prog_pkg::max_of(idx_r));
   wire [3:0] inc_val   = at_max ? btn_prog_pkg::VAL_ZERO : val_r + 4'h1;

   always_comb begin
      state_nxt  = state_r;
      idx_nxt    = idx_r;
      val_nxt    = val_r;
      dirty_nxt  = dirty_r;
      nvm_wr_nxt = 1'b0;
      nvm_nxt    = nvm_r;
      cal_wr_nxt = 1'b0;
      cal_nxt    = cal_out_r;
      unique case (state_r)
         btn_prog_pkg::ST_WAIT: begin
            if (deb_r == 2'b00 && settle_done) begin
               state_nxt = btn_prog_pkg::ST_RUN;
            end else if (hold_done && deb_r == 2'b10) begin
               state_nxt = btn_prog_pkg::ST_PROG;
               idx_nxt   = btn_prog_pkg::FIRST_IDX;
               val_nxt   = first_val;
               dirty_nxt = 1'b0;
            end else if (hold_done && deb_r == 2'b01) begin
               state_nxt = btn_prog_pkg::ST_SELFTEST;
            end else if (hold_done && deb_r == 2'b11) begin
               state_nxt = btn_prog_pkg::ST_DEFAULTS;
               idx_nxt   = btn_prog_pkg::FIRST_IDX;
            end
         end
         // No way out but reset, or calibration, which comes back here
         btn_prog_pkg::ST_PROG: begin
            if (store_press) begin
               nvm_wr_nxt = dirty_r;
               nvm_nxt    = '{idx: idx_r, val: val_r};
               idx_nxt    = next_idx;
               val_nxt    = next_val;
               dirty_nxt  = 1'b0;
            end else if (inc_press && at_joy) begin
               state_nxt = btn_prog_pkg::ST_CAL;
            end else if (inc_press) begin
               val_nxt   = inc_val;
               dirty_nxt = 1'b1;
            end
         end
         btn_prog_pkg::ST_CAL: begin
            if (store_press) begin
               cal_wr_nxt = 1'b1;
               cal_nxt    = '{lo: track_r.lo, hi: track_r.hi, mid: joy};
               state_nxt  = btn_prog_pkg::ST_PROG;
               idx_nxt    = next_idx;
               val_nxt    = next_val;
               dirty_nxt  = 1'b0;
            end
         end
         // One parameter a cycle, joystick limits last
         btn_prog_pkg::ST_DEFAULTS: begin
            if (at_joy) begin
               cal_wr_nxt = 1'b1;
               cal_nxt    = '{lo:  '{ch1: btn_prog_pkg::JOY_DEF_LO,  ch0: btn_prog_pkg::JOY_DEF_LO},
                              hi:  '{ch1: btn_prog_pkg::JOY_DEF_HI,  ch0: btn_prog_pkg::JOY_DEF_HI},
                              mid: '{ch1: btn_prog_pkg::JOY_DEF_MID, ch0: btn_prog_pkg::JOY_DEF_MID}};
               state_nxt  = btn_prog_pkg::ST_RUN;
            end else begin
               nvm_wr_nxt = 1'b1;
               nvm_nxt    = '{idx: idx_r, val: btn_prog_pkg::default_of(idx_r)};
               idx_nxt    = idx_r + 4'h1;
            end
         end
         btn_prog_pkg::ST_SELFTEST: begin
            state_nxt = btn_prog_pkg::ST_SELFTEST;
         end
         // Flash contents take effect here only through a new reset
         btn_prog_pkg::ST_RUN: begin
            state_nxt = btn_prog_pkg::ST_RUN;
         end
         default: begin
            state_nxt = btn_prog_pkg::ST_WAIT;
         end
      endcase
   end

   // State and edit registers
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_r   <= btn_prog_pkg::ST_WAIT;
         idx_r     <= btn_prog_pkg::FIRST_IDX;
         val_r     <= btn_prog_pkg::VAL_ZERO;
         dirty_r   <= 1'b0;
         nvm_wr_r  <= 1'b0;
         nvm_r     <= '0;
         cal_wr_r  <= 1'b0;
         cal_out_r <= '0;
      end else begin
         state_r   <= state_nxt;
         idx_r     <= idx_nxt;
         val_r     <= val_nxt;
         dirty_r   <= dirty_nxt;
         nvm_wr_r  <= nvm_wr_nxt;
         nvm_r     <= nvm_nxt;
         cal_wr_r  <= cal_wr_nxt;
         cal_out_r <= cal_nxt;
      end
   end

   // ---------------------------------------------------------------
   // Joystick limit tracking
   // ---------------------------------------------------------------
   wire in_cal = (state_r == btn_prog_pkg::ST_CAL);

   // Limits start inverted so the first sample sets both
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         track_r <= '0;
      end else if (!in_cal) begin
         track_r.lo <= '{ch1: btn_prog_pkg::JOY_DEF_HI, ch0: btn_prog_pkg::JOY_DEF_HI};
         track_r.hi <= '{ch1: btn_prog_pkg::JOY_DEF_LO, ch0: btn_prog_pkg::JOY_DEF_LO};
      end else if (joy_valid) begin
         if (joy.ch0 < track_r.lo.ch0) track_r.lo.ch0 <= joy.ch0;
         if (joy.ch1 < track_r.lo.ch1) track_r.lo.ch1 <= joy.ch1;
         if (joy.ch0 > track_r.hi.ch0) track_r.hi.ch0 <= joy.ch0;
         if (joy.ch1 > track_r.hi.ch1) track_r.hi.ch1 <= joy.ch1;
      end
   end

   // ---------------------------------------------------------------
   // Display and mode outputs
   // ---------------------------------------------------------------
   logic [6:0] seg_r;
   logic       prog_r;
   logic       selftest_r;
   logic       run_r;
   wire        show_first = (phase_r == 2'h0);
   wire        show_second = (phase_r == 2'h2);
   wire [6:0]  prog_second = at_joy ? btn_prog_pkg::SEG_DASH : btn_prog_pkg::seg_hex(val_r);
   wire [6:0]  prog_seg = show_first  ? btn_prog_pkg::letter_of(idx_r) :
                          show_second ? prog_second : btn_prog_pkg::SEG_BLANK;
   wire [6:0]  cal_seg  = show_first  ? btn_prog_pkg::SEG_J :
                          show_second ? btn_prog_pkg::SEG_O : btn_prog_pkg::SEG_BLANK;
   wire [6:0]  wait_seg = (deb_r == 2'b10) ? btn_prog_pkg::SEG_STEADY
                                           : btn_prog_pkg::SEG_BLANK;
   wire [6:0]  seg_nxt  = (state_nxt == btn_prog_pkg::ST_PROG) ? prog_seg :
                          (state_nxt == btn_prog_pkg::ST_CAL)  ? cal_seg  :
                          (state_nxt == btn_prog_pkg::ST_WAIT) ? wait_seg :
                                                                 btn_prog_pkg::SEG_BLANK;

   // Registered so every output comes from a flop
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         seg_r      <= btn_prog_pkg::SEG_BLANK;
         prog_r     <= 1'b0;
         selftest_r <= 1'b0;
         run_r      <= 1'b0;
      end else begin
         seg_r      <= seg_nxt;
         prog_r     <= (state_nxt == btn_prog_pkg::ST_PROG) || (state_nxt == btn_prog_pkg::ST_CAL);
         selftest_r <= (state_nxt == btn_prog_pkg::ST_SELFTEST);
         run_r      <= (state_nxt == btn_prog_pkg::ST_RUN);
      end
   end

   assign seg           = seg_r;
   assign prog_mode     = prog_r;
   assign selftest_mode = selftest_r;
   assign run_mode      = run_r;
   assign nvm_wr        = nvm_wr_r;
   assign nvm_word      = nvm_r;
   assign cal_wr        = cal_wr_r;
   assign cal_word      = cal_out_r;

endmodule : btn_prog

// ### hw/btn_prog_pkg.sv
// Constants, types and lookup functions of the front-panel programming block.
// Assumes a single 40 MHz clock domain.
package btn_prog_pkg;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int unsigned CLK_KHZ       = 32'h0000_9C40;  // 40 MHz clock in kHz
   localparam int unsigned HOLD_TIME_MS  = 32'h0000_2710;  // 10 s start-up hold
   localparam int unsigned DEB_TIME_MS   = 32'h0000_000A;  // 10 ms debounce
   localparam int unsigned FLASH_TIME_MS = 32'h0000_00FA;  // 250 ms per display phase
   localparam int unsigned HOLD_CYCLES   = HOLD_TIME_MS * CLK_KHZ;
   localparam int unsigned DEB_CYCLES    = DEB_TIME_MS * CLK_KHZ;
   localparam int unsigned FLASH_CYCLES  = FLASH_TIME_MS * CLK_KHZ;

   // ---------------------------------------------------------------
   // Parameter list
   // ---------------------------------------------------------------
   localparam int unsigned NUM_VALS = 10;                   // Valued parameters
   localparam logic [3:0]  LAST_IDX = 4'hA;                 // Joystick entry, last in list
   localparam logic [3:0]  FIRST_IDX = 4'h0;                // Input command mode
   localparam logic [3:0]  VAL_ZERO = 4'h0;
   localparam logic [7:0]  JOY_DEF_LO  = 8'h00;             // Default joystick limits
   localparam logic [7:0]  JOY_DEF_HI  = 8'hFF;
   localparam logic [7:0]  JOY_DEF_MID = 8'h80;

   // Input command mode codes
   localparam logic [3:0]  CMD_RADIO  = 4'h0;
   localparam logic [3:0]  CMD_FULLDX = 4'h1;
   localparam logic [3:0]  CMD_HALFDX = 4'h2;
   localparam logic [3:0]  CMD_ANALOG = 4'h3;

   // ---------------------------------------------------------------
   // Segment patterns, gfedcba, active high
   // ---------------------------------------------------------------
   localparam logic [6:0] SEG_BLANK  = 7'h00;
   localparam logic [6:0] SEG_STEADY = 7'h49;   // Three bars, while waiting with the Program button alone held
   localparam logic [6:0] SEG_DASH   = 7'h40;   // Calibration idle
   localparam logic [6:0] SEG_O      = 7'h5C;   // Calibration active
   localparam logic [6:0] SEG_J      = 7'h1E;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_WAIT     = 3'b000,   // Watching the buttons after reset
      ST_PROG     = 3'b001,   // Parameter programming
      ST_CAL      = 3'b010,   // Joystick calibration
      ST_SELFTEST = 3'b011,   // Self-test selected
      ST_DEFAULTS = 3'b100,   // Writing factory defaults
      ST_RUN      = 3'b101    // Normal start-up
   } state_e;

   typedef struct packed {
      logic [7:0] ch1;
      logic [7:0] ch0;
   } joy_s;

   typedef struct packed {
      joy_s lo;
      joy_s hi;
      joy_s mid;
   } cal_s;

   typedef struct packed {
      logic [3:0] idx;
      logic [3:0] val;
   } nvm_s;

   typedef logic [NUM_VALS-1:0][3:0] store_t;

   // ---------------------------------------------------------------
   // Lookups
   // ---------------------------------------------------------------
   function automatic logic [3:0] max_of(input logic [3:0] idx);
      unique case (idx)
         4'h0:    max_of = CMD_ANALOG;
         4'h1:    max_of = 4'h1;   // Only the two open-loop modes
         4'h2:    max_of = 4'h6;
         4'h3:    max_of = 4'h5;
         4'h4:    max_of = 4'h2;
         4'h5:    max_of = 4'h0;
         4'h6:    max_of = 4'h7;
         4'h7:    max_of = 4'h4;
         4'h8:    max_of = 4'h4;
         4'h9:    max_of = 4'hE;
         default: max_of = 4'h0;
      endcase
   endfunction : max_of

   function automatic logic [3:0] default_of(input logic [3:0] idx);
      unique case (idx)
         4'h0:    default_of = CMD_RADIO;
         4'h2:    default_of = 4'h5;
         4'h3:    default_of = 4'h2;
         4'h4:    default_of = 4'h2;
         4'h6:    default_of = 4'h2;
         4'h9:    default_of = 4'h7;
         default: default_of = 4'h0;
      endcase
   endfunction : default_of

   function automatic logic [6:0] letter_of(input logic [3:0] idx);
      unique case (idx)
         4'h0:    letter_of = 7'h06;   // I
         4'h1:    letter_of = 7'h39;   // C
         4'h2:    letter_of = 7'h77;   // A
         4'h3:    letter_of = 7'h6D;   // S
         4'h4:    letter_of = 7'h3E;   // U
         4'h5:    letter_of = 7'h7C;   // b
         4'h6:    letter_of = 7'h5E;   // d
         4'h7:    letter_of = 7'h79;   // E
         4'h8:    letter_of = 7'h71;   // F
         4'h9:    letter_of = 7'h38;   // L
         default: letter_of = SEG_J;
      endcase
   endfunction : letter_of

   function automatic logic [6:0] seg_hex(input logic [3:0] v);
      unique case (v)
         4'h0: seg_hex = 7'h3F;
         4'h1: seg_hex = 7'h06;
         4'h2: seg_hex = 7'h5B;
         4'h3: seg_hex = 7'h4F;
         4'h4: seg_hex = 7'h66;
         4'h5: seg_hex = 7'h6D;
         4'h6: seg_hex = 7'h7D;
         4'h7: seg_hex = 7'h07;
         4'h8: seg_hex = 7'h7F;
         4'h9: seg_hex = 7'h6F;
         4'hA: seg_hex = 7'h77;
         4'hB: seg_hex = 7'h7C;
         4'hC: seg_hex = 7'h39;
         4'hD: seg_hex = 7'h5E;
         4'hE: seg_hex = 7'h79;
         4'hF: seg_hex = 7'h71;
      endcase
   endfunction : seg_hex

endpackage : btn_prog_pkg
